// ===== inc/oag_consts.svh
/*
 * Constants for the operand address generator: widths, the internal
 * high-speed RAM window used by the stack, and the stack pointer reset value.
 * Assumes it is included by bare name from design and bench files.
 */
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH

`define ADDR_W 16
`define BYTE_W 8
`define SP_RESET 16'h0000
`define STACK_RAM_LO 16'hFE20
`define STACK_RAM_HI 16'hFEFF
`define BANK_SEL_W 2
`define BANK_NUM 4

`endif

// ===== inc/oag_pkg.sv
/*
 * Types shared by the operand address generator, its checker and its bench.
 * Assumes oag_consts.svh defines the widths.
 */
`include "oag_consts.svh"
package oag_pkg;
   // Address mode requested by the instruction decoder.
   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_HL_B,
      MODE_HL_C,
      MODE_HL_BYTE,
      MODE_PUSH,
      MODE_POP
   } addr_mode_t;

   // Reason for a stack access; all use the same pointer arithmetic.
   typedef enum logic [1:0] {
      STK_DATA,
      STK_CALL_RET,
      STK_IRQ_CTX
   } stack_cause_t;
endpackage

// ===== hw/zext_add16.sv
/*
 * Base plus zero-extended 8-bit offset, wrapping within 16 bits.
 * Assumes oag_consts.svh gives the widths.
 */
`timescale 1ns/1ps
`include "oag_consts.svh"
module zext_add16 #(
   parameter int AW = `ADDR_W,
   parameter int OW = `BYTE_W
) (
   input wire logic [AW-1:0] base,
   input wire logic [OW-1:0] offset,
   output logic [AW-1:0] sum
);
   wire [AW-1:0] offset_ext = {{(AW-OW){1'b0}}, offset};
   wire [AW:0] full_sum = {1'b0, base} + {1'b0, offset_ext};
   // The carry out of the top bit is dropped so the address wraps.
   assign sum = full_sum[AW-1:0];
endmodule // zext_add16

// ===== hw/operand_address_generator.sv
/*
 * Operand effective-address generation for the 8-bit core: based,
 * based indexed and stack addressing, with the stack pointer held here.
 * Assumes the decoder gives one request per cycle and supplies the
 * four register banks' HL, B and C contents as flat vectors.
 */
// Notes on behaviour
// - Based indexed address is HL plus zero-extended B or C.
// - Carry out of bit 15 is dropped; address wraps in 64 KB.
// - HL, B and C come from the bank chosen by two select flags.
// - Both HL+B and HL+C forms reach the whole memory space.
// - Pop uses the current stack pointer as address; push uses the decremented one.
// - Push, pop, call, return and interrupt save use stack addressing.
// - Stack accesses only reach internal high-speed RAM.
// - Based mode zero-extends its 8-bit displacement before adding.
`timescale 1ns/1ps
`include "oag_consts.svh"
module operand_address_generator #(
   parameter int AW = `ADDR_W,
   parameter int BW = `BYTE_W,
   parameter logic [15:0] RAM_LO = `STACK_RAM_LO,
   parameter logic [15:0] RAM_HI = `STACK_RAM_HI
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   input wire oag_pkg::addr_mode_t REQ_MODE,
   input wire oag_pkg::stack_cause_t REQ_CAUSE,
   input wire logic [BW-1:0] REQ_DISP,
   input wire logic BANK_SELECT_LO,
   input wire logic BANK_SELECT_HI,
   input wire logic [4*AW-1:0] BANK_BASE_PAIR,
   input wire logic [4*BW-1:0] BANK_B,
   input wire logic [4*BW-1:0] BANK_C,
   input wire logic SP_LOAD,
   input wire logic [AW-1:0] SP_LOAD_VALUE,
   output logic ADDR_VALID,
   output logic [AW-1:0] ADDR,
   output logic ADDR_IS_STACK,
   output logic STACK_FAULT,
   output logic [AW-1:0] SP
);
   // Number of register banks carried on the flat bank vectors.
   localparam int NB = `BANK_NUM;

   logic [AW-1:0] sp_q;
   logic [AW-1:0] sp_d;
   logic [AW-1:0] addr_q;
   logic [AW-1:0] addr_d;
   logic valid_q;
   logic valid_d;
   logic stack_q;
   logic stack_d;
   logic fault_q;
   logic fault_d;
   logic [AW-1:0] sum;

   // Unpacked views of the banks, one entry per bank.
   logic [AW-1:0] base_bank [NB];
   logic [BW-1:0] b_bank [NB];
   logic [BW-1:0] c_bank [NB];

   genvar gi;
   generate
      for (gi = 0; gi < NB; gi++) begin : g_bank
         assign base_bank[gi] = BANK_BASE_PAIR[gi*AW +: AW];
         assign b_bank[gi] = BANK_B[gi*BW +: BW];
         assign c_bank[gi] = BANK_C[gi*BW +: BW];
      end
   endgenerate

   // The two select flags pick one bank for HL, B and C together.
   wire [1:0] bank = {BANK_SELECT_HI, BANK_SELECT_LO};
   wire [AW-1:0] base_pair = base_bank[bank];
   wire [BW-1:0] reg_b = b_bank[bank];
   wire [BW-1:0] reg_c = c_bank[bank];

   wire mode_hl_b = REQ_MODE == oag_pkg::MODE_HL_B;
   wire mode_hl_c = REQ_MODE == oag_pkg::MODE_HL_C;
   wire mode_hl_byte = REQ_MODE == oag_pkg::MODE_HL_BYTE;
   wire is_push = REQ_MODE == oag_pkg::MODE_PUSH;
   wire is_pop = REQ_MODE == oag_pkg::MODE_POP;
   wire is_stack = is_push | is_pop;
   wire addr_mode = mode_hl_b | mode_hl_c | mode_hl_byte;

   // A pointer load wins over any request in the same cycle.
   wire take = REQ_VALID && !SP_LOAD;
   wire take_stack = take && is_stack;
   wire take_addr = take && addr_mode;

   // B, C or displacement, all zero-extended inside the adder.
   wire [BW-1:0] index_sel = mode_hl_c ? reg_c : reg_b;
   wire [BW-1:0] offset = mode_hl_byte ? REQ_DISP : index_sel;

   zext_add16 #(
      .AW(AW),
      .OW(BW)
   ) u_add (
      .base(base_pair),
      .offset(offset),
      .sum(sum)
   );

   wire [AW-1:0] one = {{(AW-1){1'b0}}, 1'b1};
   wire [AW-1:0] sp_dec = sp_q - one;
   wire [AW-1:0] sp_inc = sp_q + one;

   // Push writes at the decremented pointer; pop reads at the current one.
   wire [AW-1:0] stack_addr = is_push ? sp_dec : sp_q;
   wire [AW-1:0] sp_next = is_push ? sp_dec : sp_inc;

   // Out-of-RAM stack accesses are suppressed, not redirected, so a bad
   // pointer is visible to software rather than corrupting other areas.
   wire stack_in_ram = stack_addr >= RAM_LO && stack_addr <= RAM_HI;
   wire stack_ok = take_stack && stack_in_ram;
   wire stack_bad = take_stack && !stack_in_ram;

   // Next values of the stack pointer and of the address register.
   assign sp_d = SP_LOAD ? SP_LOAD_VALUE :
      stack_ok ? sp_next : sp_q;
   assign addr_d = stack_ok ? stack_addr :
      take_addr ? sum : addr_q;

   // The strobes are one-cycle pulses; the address itself is held.
   assign valid_d = stack_ok | take_addr;
   assign stack_d = stack_ok;
   assign fault_d = stack_bad;

   // Stack pointer. Its reset value lies outside the RAM window, so the
   // pointer must be loaded before the first stack access succeeds.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sp_q <= `SP_RESET;
      end else begin
         sp_q <= sp_d;
      end
   end

   // Last operand address, held until the next accepted request.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         addr_q <= {AW{1'b0}};
      end else begin
         addr_q <= addr_d;
      end
   end

   // Address strobe.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // Marks a strobe that belongs to a stack access.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         stack_q <= 1'b0;
      end else begin
         stack_q <= stack_d;
      end
   end

   // Refused stack access, a single-cycle pulse.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   // Outputs come straight from the registers above.

   assign ADDR_VALID = valid_q;
   assign ADDR = addr_q;
   assign ADDR_IS_STACK = stack_q;
   assign STACK_FAULT = fault_q;
   assign SP = sp_q;
endmodule // operand_address_generator

// ===== test/oag_chk.sv
/* Address and stack checks. Assumes binding to the generator top. */
`timescale 1ns/1ps
`include "oag_consts.svh"
module oag_chk (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   input wire oag_pkg::addr_mode_t REQ_MODE,
   input wire logic BANK_SELECT_LO,
   input wire logic BANK_SELECT_HI,
   input wire logic [63:0] BANK_BASE_PAIR,
   input wire logic [31:0] BANK_B,
   input wire logic [31:0] BANK_C,
   input wire logic SP_LOAD,
   input wire logic ADDR_VALID,
   input wire logic [15:0] ADDR,
   input wire logic ADDR_IS_STACK,
   input wire logic STACK_FAULT,
   input wire logic [15:0] SP
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire tk = REQ_VALID && !SP_LOAD;
   wire pu = tk && REQ_MODE == oag_pkg::MODE_PUSH;
   wire po = tk && REQ_MODE == oag_pkg::MODE_POP;
   // A push is in range when the decremented pointer lands in the RAM.
   wire ok = SP > `STACK_RAM_LO && SP <= `STACK_RAM_HI + 16'h0001;
   wire [1:0] bk = {BANK_SELECT_HI, BANK_SELECT_LO};
   wire [15:0] base = BANK_BASE_PAIR[bk*16 +: 16];
   wire [15:0] sum_b = base + {8'h00, BANK_B[bk*8 +: 8]};
   wire [15:0] sum_c = base + {8'h00, BANK_C[bk*8 +: 8]};
   sequence s_push_in; pu && ok; endsequence
   sequence s_stack_out; ADDR_VALID && ADDR_IS_STACK; endsequence
   property p_pu;
      s_push_in |=> s_stack_out ##0
         (ADDR == $past(SP) - 16'h0001 && SP == ADDR);
   endproperty
   a_pu: assert property (p_pu) else $error("push");
   property p_pf; pu && !ok |=> STACK_FAULT && $stable(SP); endproperty
   a_pf: assert property (p_pf) else $error("fault");
   property p_po; po |-> ##1 ADDR_IS_STACK |-> ADDR == $past(SP); endproperty
   a_po: assert property (p_po) else $error("pop");
   property p_sm; ADDR_IS_STACK |-> $past(pu || po); endproperty
   a_sm: assert property (p_sm) else $error("mode");
   property p_bi; tk && REQ_MODE == oag_pkg::MODE_HL_B |=>
      ADDR_VALID && !ADDR_IS_STACK && ADDR == $past(sum_b); endproperty
   a_bi: assert property (p_bi) else $error("index b");
   property p_ci; tk && REQ_MODE == oag_pkg::MODE_HL_C |=>
      ADDR_VALID && !ADDR_IS_STACK && ADDR == $past(sum_c); endproperty
   a_ci: assert property (p_ci) else $error("index c");
   property p_rg; ADDR_IS_STACK |->
      ADDR >= `STACK_RAM_LO && ADDR <= `STACK_RAM_HI; endproperty
   a_rg: assert property (p_rg) else $error("range");
   property p_ex; !(ADDR_VALID && STACK_FAULT); endproperty
   a_ex: assert property (p_ex) else $error("both");
endmodule // oag_chk
bind operand_address_generator oag_chk u_chk (.*);

// ===== test/oag_regbank.sv
/* Register bank model. Assumes the bench sets the seeds. */
`timescale 1ns/1ps
module oag_regbank (
   input wire logic [15:0] hl,
   input wire logic [7:0] b,
   output logic [63:0] bp,
   output logic [31:0] rb
);
   // Banks differ so a wrong bank select shows.
   assign bp = {hl ^ 16'h3000, hl ^ 16'h2000, hl ^ 16'h1000, hl};
   assign rb = {b ^ 8'h30, b ^ 8'h20, b ^ 8'h10, b};
endmodule // oag_regbank

// ===== test/operand_address_generator_test.sv
/* Bench. Assumes design, package and bank model are compiled. */
`timescale 1ns/1ps
module operand_address_generator_test;
   logic clk, rst_n, rv, ld, lo, hi, av, st, ft;
   oag_pkg::addr_mode_t md;
   logic [7:0] d;
   logic [15:0] hl, lv, a, sp;
   logic [63:0] bp;
   logic [31:0] rb, rc;
   oag_pkg::stack_cause_t cs;
   int mismatches, comparisons;
   oag_regbank u_rb (.hl(hl), .b(8'hF0), .bp(bp), .rb(rb));
   oag_regbank u_rc (.hl(hl), .b(8'h0F), .bp(), .rb(rc));
   operand_address_generator DUT (.CLK_SYS(clk), .RST_N(rst_n),
      .REQ_VALID(rv), .REQ_MODE(md), .REQ_CAUSE(cs),
      .REQ_DISP(d), .BANK_SELECT_LO(lo), .BANK_SELECT_HI(hi),
      .BANK_BASE_PAIR(bp), .BANK_B(rb), .BANK_C(rc), .SP_LOAD(ld),
      .SP_LOAD_VALUE(lv), .ADDR_VALID(av), .ADDR(a), .ADDR_IS_STACK(st),
      .STACK_FAULT(ft), .SP(sp));
   task check(input logic [31:0] g, e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t %h %h", $time, g, e);
      end
   endtask
   task req(input oag_pkg::addr_mode_t m);
      @(posedge clk) #1;
      md = m;
      rv = 1;
      @(posedge clk) #1 rv = 0;
   endtask
   task t_index;
      for (int k = 0; k < 4; k++) begin
         {hi, lo} = 2'(k);
         req(oag_pkg::MODE_HL_B);
         check({a, av}, {16'((hl ^ 16'(k << 12)) +
            16'(8'hF0 ^ 8'(k << 4))), 1'b1});
         req(oag_pkg::MODE_HL_C);
         check({a, av}, {16'((hl ^ 16'(k << 12)) +
            16'(8'h0F ^ 8'(k << 4))), 1'b1});
         req(oag_pkg::MODE_HL_BYTE);
         check(a, 16'((hl ^ 16'(k << 12)) + 16'h0090));
      end
      req(oag_pkg::MODE_NONE);
      check({ft, av}, 2'b00);
   endtask
   task t_stack;
      ld = 1;
      @(posedge clk) #1 ld = 0;
      check(sp, 32'h0000_FE21);
      cs = oag_pkg::STK_IRQ_CTX;
      req(oag_pkg::MODE_PUSH);
      check({a, st, av}, {16'hFE20, 2'b11});
      check(sp, 32'h0000_FE20);
      req(oag_pkg::MODE_PUSH);
      check({sp, ft, av}, {16'hFE20, 2'b10});
      cs = oag_pkg::STK_CALL_RET;
      req(oag_pkg::MODE_POP);
      check({a, sp}, {16'hFE20, 16'hFE21});
   endtask
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   initial begin
      #20000 mismatches++;
      tally_and_finish;
   end
   initial begin
      {rst_n, rv, ld, lo, hi} = 0;
      md = oag_pkg::MODE_NONE;
      cs = oag_pkg::STK_DATA;
      {d, hl, lv} = {8'h90, 16'hFFF0, 16'hFE21};
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      t_index;
      t_stack;
      tally_and_finish;
   end
endmodule // operand_address_generator_test
